// ===== rtl/drop_detect_pkg.sv
// constants shared by the supply drop detector control
package drop_detect_pkg;
  // power mode field codes
  localparam logic [1:0] PMODE_TOTAL_DOWN = 2'h3;
  localparam int PMODE_DOWN_BIT = 1;
  // flag bit positions in the reset source register
  localparam int RESET_SOURCE_REG_POWER_ON_BIT = 4;
  localparam int RESET_SOURCE_REG_RESET_FLAG_BIT = 5;
  localparam int RESET_SOURCE_REG_IRQ_FLAG_BIT = 6;
  // bit positions of the trip selection and interrupt enable controls
  localparam int UCFG_SEL_HI_BIT = 5;
  localparam int UCFG_SEL_LO_BIT = 3;
  localparam int IRQCFG_SEL_HI_BIT = 1;
  localparam int IRQCFG_SEL_LO_BIT = 0;
  localparam int POWER_CONTROL_REG_IRQ_DETECT_BIT = 4;
  localparam int IRQ_ENABLE_REG0_SOURCE_BIT = 5;
  localparam int IRQ_ENABLE_REG0_GLOBAL_BIT = 7;
  // flag reset values
  localparam logic FLAG_RESET_VALUE = 1'b0;
  // trip level codes, millivolts
  localparam logic [11:0] TRIP_2V2 = 12'h898;
  localparam logic [11:0] TRIP_2V4 = 12'h960;
  localparam logic [11:0] TRIP_2V6 = 12'hA28;
  localparam logic [11:0] TRIP_3V0 = 12'hBB8;
  localparam logic [11:0] TRIP_3V2 = 12'hC80;
  localparam logic [11:0] TRIP_NONE = 12'h000;
  // synchroniser depth
  localparam int SYNC_STAGES = 3;
endpackage : drop_detect_pkg

// ===== rtl/brownout_detect_control.sv
// digital control around the supply drop detector: reset, interrupt, flash guard
// Notes on behaviour
// RULE1: detector trip always raises processor reset; the code raises it only outside total power-down.
// RULE2: total power-down disables all detection.
// RULE3: interrupt detection needs irq detect enable.
// RULE4: interrupt needs detect, source, global enables.
// RULE5: reset flag bit5, default 0, set on trip; RST does not load it.
// RULE6: irq flag bit6, default 0, set on trip.
// RULE7: reset trip from config byte bits 5,3.
// RULE8: irq trip from config register bits 1,0.
// RULE9: trip encoding table; other combinations reserved.
// RULE10: software keeps reset level below irq level.
// RULE11: flash guard blocks program below 2.4V.
// RULE12: condition follows supply against selected level.
// RULE13: power-on flag set also sets reset flag.
// RULE14: flags sticky until software writes zero.
// RULE15: analog trips synchronised before use.
`timescale 1ns/10ps
module brownout_detect_control #(
  parameter int STAGES = drop_detect_pkg::SYNC_STAGES
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic [7:0] USER_CONFIG_BYTE1,
  input wire logic [7:0] DROP_DETECT_CONFIG_REG,
  input wire logic [7:0] POWER_CONTROL_REG,
  input wire logic [7:0] IRQ_ENABLE_REG0,
  input wire logic RESET_TRIP_RAW,
  input wire logic IRQ_TRIP_RAW,
  input wire logic FLASH_TRIP_RAW,
  input wire logic POWER_ON_SET,
  input wire logic RESET_FLAG_CLEAR,
  input wire logic IRQ_FLAG_CLEAR,
  output logic CPU_RESET,
  output logic IRQ_REQUEST,
  output logic FLASH_BLOCK,
  output logic DROP_RESET_FLAG,
  output logic DROP_IRQ_FLAG,
  output logic [11:0] RESET_TRIP_MV,
  output logic [11:0] IRQ_TRIP_MV,
  output logic TRIP_SEL_RESERVED
);
  // synchroniser chains, one per analog trip
  logic [STAGES-1:0] rst_sync_reg, rst_sync_next;
  logic [STAGES-1:0] irq_sync_reg, irq_sync_next;
  logic [STAGES-1:0] fl_sync_reg, fl_sync_next;
  // filtered levels, change once last two stages agree
  logic rst_lvl_reg, rst_lvl_next;
  logic irq_lvl_reg, irq_lvl_next;
  logic fl_lvl_reg, fl_lvl_next;
  // sticky flags
  logic rflag_reg, rflag_next;
  logic iflag_reg, iflag_next;
  // registered outputs
  logic cpu_rst_reg, cpu_rst_next;
  logic irq_reg, irq_next;
  logic flash_reg, flash_next;
  logic [11:0] rmv_reg, rmv_next;
  logic [11:0] imv_reg, imv_next;
  logic resv_reg, resv_next;
  // decoded control bits
  // these stay combinational: they only gate registered outputs one edge later,
  // so a mode write shows on the outputs after exactly one clock
  logic total_down;
  logic flash_on;
  logic irq_detect_on;
  logic irq_deliver;
  logic [1:0] rsel;
  logic [1:0] isel;

  // trip table lookup; returns {reserved, reset mv, irq mv}
  function automatic logic [24:0] trip_lookup(input logic [1:0] r, input logic [1:0] i);
    logic [24:0] v;
    v = {1'b1, drop_detect_pkg::TRIP_NONE, drop_detect_pkg::TRIP_NONE};
    case ({r, i}) // RULE9
      4'h5: v = {1'b0, drop_detect_pkg::TRIP_2V2, drop_detect_pkg::TRIP_2V4};
      4'h6: v = {1'b0, drop_detect_pkg::TRIP_2V2, drop_detect_pkg::TRIP_2V6};
      4'h7: v = {1'b0, drop_detect_pkg::TRIP_2V2, drop_detect_pkg::TRIP_3V2};
      4'hA: v = {1'b0, drop_detect_pkg::TRIP_2V4, drop_detect_pkg::TRIP_2V6};
      4'hB: v = {1'b0, drop_detect_pkg::TRIP_2V4, drop_detect_pkg::TRIP_3V2};
      4'hF: v = {1'b0, drop_detect_pkg::TRIP_3V0, drop_detect_pkg::TRIP_3V2};
      default: v = {1'b1, drop_detect_pkg::TRIP_NONE, drop_detect_pkg::TRIP_NONE};
    endcase
    return v;
  endfunction : trip_lookup

  // control decode from the mode and enable bits
  always_comb begin
    total_down = (POWER_CONTROL_REG[1:0] == drop_detect_pkg::PMODE_TOTAL_DOWN); // RULE2
    flash_on = ~POWER_CONTROL_REG[drop_detect_pkg::PMODE_DOWN_BIT]; // RULE11
    irq_detect_on = ~total_down & POWER_CONTROL_REG[drop_detect_pkg::POWER_CONTROL_REG_IRQ_DETECT_BIT]; // RULE3
    irq_deliver = irq_detect_on & IRQ_ENABLE_REG0[drop_detect_pkg::IRQ_ENABLE_REG0_SOURCE_BIT]
                  & IRQ_ENABLE_REG0[drop_detect_pkg::IRQ_ENABLE_REG0_GLOBAL_BIT]; // RULE4
    rsel = {USER_CONFIG_BYTE1[drop_detect_pkg::UCFG_SEL_HI_BIT],
            USER_CONFIG_BYTE1[drop_detect_pkg::UCFG_SEL_LO_BIT]}; // RULE7
    isel = {DROP_DETECT_CONFIG_REG[drop_detect_pkg::IRQCFG_SEL_HI_BIT],
            DROP_DETECT_CONFIG_REG[drop_detect_pkg::IRQCFG_SEL_LO_BIT]}; // RULE8
  end

  // synchroniser and level filter next values
  // a trip shorter than two samples never reaches the level, which filters
  // comparator chatter at the cost of three to four cycles of latency
  always_comb begin
    rst_sync_next = {rst_sync_reg[STAGES-2:0], RESET_TRIP_RAW}; // RULE15
    irq_sync_next = {irq_sync_reg[STAGES-2:0], IRQ_TRIP_RAW}; // RULE15
    fl_sync_next = {fl_sync_reg[STAGES-2:0], FLASH_TRIP_RAW}; // RULE15
    // only the last two stages are looked at; the first is left to settle
    rst_lvl_next = rst_lvl_reg;
    if (rst_sync_reg[STAGES-1] == rst_sync_reg[STAGES-2]) begin // RULE12
      rst_lvl_next = rst_sync_reg[STAGES-1];
    end
    irq_lvl_next = irq_lvl_reg;
    if (irq_sync_reg[STAGES-1] == irq_sync_reg[STAGES-2]) begin // RULE12
      irq_lvl_next = irq_sync_reg[STAGES-1];
    end
    fl_lvl_next = fl_lvl_reg;
    if (fl_sync_reg[STAGES-1] == fl_sync_reg[STAGES-2]) begin
      fl_lvl_next = fl_sync_reg[STAGES-1];
    end
  end

  // flags and outputs next values
  // the flags are set from the filtered level, not the raw trip, so a glitch
  // that the filter rejects leaves no trace in the reset source bits
  always_comb begin
    logic [24:0] t;
    t = trip_lookup(rsel, isel);
    rmv_next = t[23:12];
    imv_next = t[11:0];
    resv_next = t[24];
    // reset cannot be masked by software, only by total power-down
    cpu_rst_next = rst_lvl_reg & ~total_down; // RULE1 RULE2
    irq_next = irq_lvl_reg & irq_deliver; // RULE4
    flash_next = fl_lvl_reg & flash_on; // RULE11
    // set wins over clear
    rflag_next = rflag_reg;
    if (RESET_FLAG_CLEAR) begin // RULE14
      rflag_next = 1'b0;
    end
    if ((rst_lvl_reg & ~total_down) | POWER_ON_SET) begin // RULE5 RULE13
      rflag_next = 1'b1;
    end
    iflag_next = iflag_reg;
    if (IRQ_FLAG_CLEAR) begin // RULE14
      iflag_next = 1'b0;
    end
    if (irq_lvl_reg & irq_detect_on) begin // RULE6
      iflag_next = 1'b1;
    end
  end

  // synchroniser registers; cleared by reset to the known no-trip state
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      rst_sync_reg <= '0;
      irq_sync_reg <= '0;
      fl_sync_reg <= '0;
      rst_lvl_reg <= 1'b0;
      irq_lvl_reg <= 1'b0;
      fl_lvl_reg <= 1'b0;
    end else begin
      rst_sync_reg <= rst_sync_next;
      irq_sync_reg <= irq_sync_next;
      fl_sync_reg <= fl_sync_next;
      rst_lvl_reg <= rst_lvl_next;
      irq_lvl_reg <= irq_lvl_next;
      fl_lvl_reg <= fl_lvl_next;
    end
  end

  // output registers; the reset flag is not cleared by RST so it survives
  // the very reset it records
  always_ff @(posedge REF_CLK) begin
    rflag_reg <= rflag_next; // RULE14
    if (RST) begin
      iflag_reg <= drop_detect_pkg::FLAG_RESET_VALUE;
      cpu_rst_reg <= 1'b0;
      irq_reg <= 1'b0;
      flash_reg <= 1'b0;
      rmv_reg <= drop_detect_pkg::TRIP_NONE;
      imv_reg <= drop_detect_pkg::TRIP_NONE;
      resv_reg <= 1'b1;
    end else begin
      iflag_reg <= iflag_next;
      cpu_rst_reg <= cpu_rst_next;
      irq_reg <= irq_next;
      flash_reg <= flash_next;
      rmv_reg <= rmv_next;
      imv_reg <= imv_next;
      resv_reg <= resv_next;
    end
  end

  // port drive
  assign CPU_RESET = cpu_rst_reg;
  assign IRQ_REQUEST = irq_reg;
  assign FLASH_BLOCK = flash_reg;
  assign DROP_RESET_FLAG = rflag_reg;
  assign DROP_IRQ_FLAG = iflag_reg;
  assign RESET_TRIP_MV = rmv_reg;
  assign IRQ_TRIP_MV = imv_reg;
  assign TRIP_SEL_RESERVED = resv_reg;

  // reset follows the filtered trip unless in total power-down
  reset_follow_a: assert property (@(posedge REF_CLK) disable iff (RST)
    (rst_lvl_reg && !total_down) |=> CPU_RESET) // RULE1
    else $error("reset not raised on trip");
  // no reset or interrupt comes out in total power-down
  total_down_a: assert property (@(posedge REF_CLK) disable iff (RST)
    $past(total_down) |-> (!CPU_RESET && !IRQ_REQUEST)) // RULE2
    else $error("output active in total power-down");
  // no interrupt without detect enable
  irq_detect_a: assert property (@(posedge REF_CLK) disable iff (RST)
    !POWER_CONTROL_REG[drop_detect_pkg::POWER_CONTROL_REG_IRQ_DETECT_BIT] |=> !IRQ_REQUEST) // RULE3
    else $error("interrupt without detect enable");
  // interrupt requires all three enables
  irq_gate_a: assert property (@(posedge REF_CLK) disable iff (RST)
    IRQ_REQUEST |-> $past(irq_deliver && irq_lvl_reg)) // RULE4
    else $error("interrupt without full enables");
  // reset flag set after trip
  rflag_set_a: assert property (@(posedge REF_CLK) disable iff (RST)
    (rst_lvl_reg && !total_down) |=> DROP_RESET_FLAG) // RULE5
    else $error("reset flag not set");
  // irq flag set after trip
  iflag_set_a: assert property (@(posedge REF_CLK) disable iff (RST)
    (irq_lvl_reg && irq_detect_on) |=> DROP_IRQ_FLAG) // RULE6
    else $error("irq flag not set");
  // power-on sets the reset flag
  power_on_a: assert property (@(posedge REF_CLK) POWER_ON_SET |=> DROP_RESET_FLAG) // RULE13
    else $error("power-on did not set reset flag");
  // irq flag stays set without a clear
  sticky_flag_a: assert property (@(posedge REF_CLK) disable iff (RST)
    (DROP_IRQ_FLAG && !IRQ_FLAG_CLEAR) |=> DROP_IRQ_FLAG) // RULE14
    else $error("irq flag dropped without clear");
  // flash guard follows trip outside power-down
  flash_guard_a: assert property (@(posedge REF_CLK) disable iff (RST)
    (fl_lvl_reg && flash_on) |=> FLASH_BLOCK) // RULE11
    else $error("flash not blocked");
  // raw trip takes at least three cycles to reach the level
  sync_delay_a: assert property (@(posedge REF_CLK) disable iff (RST)
    $rose(rst_lvl_reg) |-> $past(RESET_TRIP_RAW, 3)) // RULE15
    else $error("trip bypassed synchroniser");
  // reset selection 00 is flagged reserved
  trip_table_a: assert property (@(posedge REF_CLK) disable iff (RST)
    (rsel == 2'h0) |=> TRIP_SEL_RESERVED) // RULE9
    else $error("reserved selection not flagged");

  // the checks below cover release paths and the flag gating; they matter
  // because a flag stuck high or an output slow to drop would pass the
  // set-side checks above unnoticed

  // reset flag keeps its value through RST and without a clear
  rflag_sticky_a: assert property (@(posedge REF_CLK)
    (DROP_RESET_FLAG && !RESET_FLAG_CLEAR) |=> DROP_RESET_FLAG) // RULE14
    else $error("reset flag dropped without clear");
  // reset flag rises only from a trip or the power-on event
  rflag_gate_a: assert property (@(posedge REF_CLK) disable iff (RST)
    $rose(DROP_RESET_FLAG) |-> $past(POWER_ON_SET || (rst_lvl_reg && !total_down))) // RULE5
    else $error("reset flag set without cause");
  // irq flag rises only while interrupt detection is on
  iflag_gate_a: assert property (@(posedge REF_CLK) disable iff (RST)
    $rose(DROP_IRQ_FLAG) |-> $past(irq_lvl_reg && irq_detect_on)) // RULE6
    else $error("irq flag set while detection off");
  // flash guard off while the power-down bit is set
  flash_off_a: assert property (@(posedge REF_CLK) disable iff (RST)
    !flash_on |=> !FLASH_BLOCK) // RULE11
    else $error("flash blocked in power-down");
  // reset drops once the supply is back
  reset_release_a: assert property (@(posedge REF_CLK) disable iff (RST)
    !rst_lvl_reg |=> !CPU_RESET) // RULE12
    else $error("reset held after supply recovered");
  // interrupt drops once the supply is back
  irq_release_a: assert property (@(posedge REF_CLK) disable iff (RST)
    !irq_lvl_reg |=> !IRQ_REQUEST) // RULE12
    else $error("interrupt held after supply recovered");
  // every legal pair puts the reset level below the interrupt level
  level_order_a: assert property (@(posedge REF_CLK) disable iff (RST)
    !TRIP_SEL_RESERVED |-> (RESET_TRIP_MV < IRQ_TRIP_MV)) // RULE9
    else $error("legal selection with reset level not below irq level");
  // flash trip also passes the synchroniser
  flash_sync_a: assert property (@(posedge REF_CLK) disable iff (RST)
    $rose(fl_lvl_reg) |-> $past(FLASH_TRIP_RAW, 3)) // RULE15
    else $error("flash trip bypassed synchroniser");
endmodule : brownout_detect_control

// ===== test/testbench.sv
// self-checking bench for the supply drop detector control
`timescale 1ns/10ps
module testbench;
  logic ref_clk = 1'b0; // 125 MHz system clock
  logic rst = 1'b1; // synchronous reset, active high
  logic [7:0] ucfg = 8'h00; // user config byte
  logic [7:0] dcfg = 8'h00; // irq trip config
  logic [7:0] power_control_reg = 8'h00; // power mode and irq detect enable
  logic [7:0] ien = 8'h00; // irq source and global enables
  logic rtrip = 1'b0; // analog reset trip
  logic itrip = 1'b0; // analog irq trip
  logic ftrip = 1'b0; // analog flash trip
  logic pon = 1'b0; // power-on event
  logic rclr = 1'b0; // reset flag clear
  logic iclr = 1'b0; // irq flag clear
  logic cpu_reset, irq_request, flash_block, rflag, iflag, resv;
  logic [11:0] rmv, imv;
  int bad_count = 0; // mismatches
  int samples_checked = 0; // comparisons made
  int cycles = 0; // hang guard
  // free-running clock
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  brownout_detect_control dut (.REF_CLK(ref_clk), .RST(rst), .USER_CONFIG_BYTE1(ucfg),
    .DROP_DETECT_CONFIG_REG(dcfg), .POWER_CONTROL_REG(power_control_reg), .IRQ_ENABLE_REG0(ien),
    .RESET_TRIP_RAW(rtrip), .IRQ_TRIP_RAW(itrip), .FLASH_TRIP_RAW(ftrip), .POWER_ON_SET(pon),
    .RESET_FLAG_CLEAR(rclr), .IRQ_FLAG_CLEAR(iclr), .CPU_RESET(cpu_reset), .IRQ_REQUEST(irq_request),
    .FLASH_BLOCK(flash_block), .DROP_RESET_FLAG(rflag), .DROP_IRQ_FLAG(iflag),
    .RESET_TRIP_MV(rmv), .IRQ_TRIP_MV(imv), .TRIP_SEL_RESERVED(resv));
  // the whole run needs under a thousand cycles
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      give_verdict();
    end
  end
  // inputs move on the falling edge only
  task automatic step(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : step
  task automatic cmp1(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp1
  task automatic cmp12(input string what, input logic [11:0] exp, input logic [11:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp12
  // expected {reserved, reset level, irq level} for a selection pair
  function automatic logic [24:0] exp_trip(input logic [3:0] sel);
    case (sel)
      4'h5: return {1'b0, drop_detect_pkg::TRIP_2V2, drop_detect_pkg::TRIP_2V4};
      4'h6: return {1'b0, drop_detect_pkg::TRIP_2V2, drop_detect_pkg::TRIP_2V6};
      4'h7: return {1'b0, drop_detect_pkg::TRIP_2V2, drop_detect_pkg::TRIP_3V2};
      4'hA: return {1'b0, drop_detect_pkg::TRIP_2V4, drop_detect_pkg::TRIP_2V6};
      4'hB: return {1'b0, drop_detect_pkg::TRIP_2V4, drop_detect_pkg::TRIP_3V2};
      4'hF: return {1'b0, drop_detect_pkg::TRIP_3V0, drop_detect_pkg::TRIP_3V2};
      default: return {1'b1, drop_detect_pkg::TRIP_NONE, drop_detect_pkg::TRIP_NONE};
    endcase
  endfunction : exp_trip
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict
  // main sequence
  initial begin
    logic [24:0] e;
    logic en;
    void'($urandom(32'h4333));
    step(5);
    rst = 1'b0;
    // the reset flag keeps its value through reset, so clear it first
    rclr = 1'b1;
    iclr = 1'b1;
    step(1);
    rclr = 1'b0;
    iclr = 1'b0;
    step(1);
    cmp1("reset flag", 1'b0, rflag);
    cmp1("irq flag", 1'b0, iflag);
    // every selection pair, other config bits random
    for (int k = 0; k < 16; k++) begin
      ucfg = 8'($urandom());
      ucfg[5] = k[3];
      ucfg[3] = k[2];
      dcfg = 8'($urandom());
      dcfg[1:0] = k[1:0];
      step(2);
      e = exp_trip(k[3:0]);
      cmp1("reserved", e[24], resv);
      cmp12("reset mv", e[23:12], rmv);
      cmp12("irq mv", e[11:0], imv);
      cmp1("level order", ~e[24], rmv < imv);
    end
    // reset trip in each power mode
    for (int m = 0; m < 4; m++) begin
      power_control_reg = 8'($urandom());
      power_control_reg[1:0] = m[1:0];
      rclr = 1'b1;
      step(1);
      rclr = 1'b0;
      rtrip = 1'b1;
      step(2);
      cmp1("cpu reset early", 1'b0, cpu_reset);
      step(6);
      cmp1("cpu reset", m != 3, cpu_reset);
      cmp1("reset flag set", m != 3, rflag);
      rtrip = 1'b0;
      step(8);
      cmp1("cpu reset release", 1'b0, cpu_reset);
      cmp1("reset flag held", m != 3, rflag);
    end
    // irq gating, corners first then random enables
    for (int k = 0; k < 16; k++) begin
      power_control_reg = 8'($urandom());
      ien = 8'($urandom());
      if (k < 2) begin
        power_control_reg[4] = ~k[0];
        power_control_reg[1:0] = 2'h0;
        ien[7] = 1'b1;
        ien[5] = 1'b1;
      end
      iclr = 1'b1;
      step(1);
      iclr = 1'b0;
      itrip = 1'b1;
      step(8);
      en = (power_control_reg[1:0] != 2'h3) && power_control_reg[4];
      cmp1("irq request", en && ien[5] && ien[7], irq_request);
      cmp1("irq flag set", en, iflag);
      itrip = 1'b0;
      step(8);
      cmp1("irq request drop", 1'b0, irq_request);
      cmp1("irq flag held", en, iflag);
    end
    // flash guard gated only by the power-down bit
    ftrip = 1'b1;
    for (int m = 0; m < 4; m++) begin
      power_control_reg[1:0] = m[1:0];
      step(8);
      cmp1("flash block", ~m[1], flash_block);
    end
    ftrip = 1'b0;
    step(8);
    cmp1("flash block clear", 1'b0, flash_block);
    // power-on event also marks the reset flag
    rclr = 1'b1;
    step(1);
    rclr = 1'b0;
    step(1);
    cmp1("reset flag cleared", 1'b0, rflag);
    pon = 1'b1;
    step(1);
    pon = 1'b0;
    step(2);
    cmp1("reset flag power-on", 1'b1, rflag);
    // mid-run reset: reset flag survives, the rest clears
    rst = 1'b1;
    step(5);
    rst = 1'b0;
    step(1);
    cmp1("reset flag survives", 1'b1, rflag);
    cmp1("irq flag after reset", 1'b0, iflag);
    cmp1("cpu reset after reset", 1'b0, cpu_reset);
    // set wins over a clear in the same cycle
    rclr = 1'b1;
    pon = 1'b1;
    step(1);
    rclr = 1'b0;
    pon = 1'b0;
    step(1);
    cmp1("reset flag set wins", 1'b1, rflag);
    give_verdict();
  end
endmodule : testbench
